// File: dbirq_pkg.sv
package dbirq_pkg;

   localparam int ADR_W   = 8;
   localparam int DAT_W   = 32;
   localparam int SEL_W   = 4;
   localparam int SIDE_W  = 16;
   localparam int PRI_LSB = 0;
   localparam int SEC_LSB = 16;
   localparam int EVT_W   = 2;
   localparam int EVT_PRI = 0;
   localparam int EVT_SEC = 1;

   localparam logic [ADR_W-1:0] OFS_REQ_CLR  = 8'h70;
   localparam logic [ADR_W-1:0] OFS_REQ_SET  = 8'h74;
   localparam logic [ADR_W-1:0] OFS_MSK_CLR  = 8'h78;
   localparam logic [ADR_W-1:0] OFS_MSK_SET  = 8'h7C;
   localparam logic [ADR_W-1:0] OFS_EVT_STAT = 8'hC0;
   localparam logic [ADR_W-1:0] OFS_EVT_MASK = 8'hC4;

   localparam logic [SIDE_W-1:0] REQ_RST     = 16'h0000;
   localparam logic [SIDE_W-1:0] MSK_RST     = 16'hFFFF;
   localparam logic [EVT_W-1:0]  EVT_RST     = 2'h0;
   localparam logic [EVT_W-1:0]  EVT_MSK_RST = 2'h3;
   localparam logic [DAT_W-1:0]  DAT_RST     = 32'h0000_0000;
   localparam logic [DAT_W-1:0]  UNMAPPED_RD = 32'h0000_0000;

   // cycles from the taking edge to the edge where ack is first seen high
   localparam int ACK_LATENCY = 1;

   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } dbirq_bus_t;

endpackage

// File: dbirq_w1_reg.sv
`timescale 1ns/1ps
module dbirq_w1_reg #(
   parameter int               WIDTH   = 16,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] setBits,
   input  wire logic [WIDTH-1:0] clrBits,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] qFf;
   logic [WIDTH-1:0] nxt_q;

   // set is applied after clear so a set in the clearing cycle is kept
   always_comb begin
      nxt_q = qFf;
      if (clkEn) begin
         nxt_q = (qFf & ~clrBits) | setBits;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         qFf <= RST_VAL;
      end else begin
         qFf <= nxt_q;
      end
   end

   assign q = qFf;

endmodule // dbirq_w1_reg

// File: dbirq_top.sv
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module dbirq_top
   import dbirq_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             arst_n,
   input  wire logic             clkEn,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [SEL_W-1:0] wb_sel_i,
   input  wire logic [DAT_W-1:0] wb_dat_i,
   output logic      [DAT_W-1:0] wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  priIrq,
   output logic                  secIrq,
   output logic                  irqOut
);

   // bus slave state
   dbirq_bus_t       busStFf;
   dbirq_bus_t       nxt_busSt;
   logic             ackFf;
   logic             nxt_ack;
   logic [DAT_W-1:0] datFf;
   logic [DAT_W-1:0] nxt_dat;

   // interrupt outputs
   logic             priIrqFf;
   logic             nxt_priIrq;
   logic             secIrqFf;
   logic             nxt_secIrq;
   logic             irqOutFf;
   logic             nxt_irqOut;

   // decode
   logic             take;
   logic             wrDo;
   logic [DAT_W-1:0] selMask;
   logic [DAT_W-1:0] wrData;
   logic             hitReqClr;
   logic             hitReqSet;
   logic             hitMskClr;
   logic             hitMskSet;
   logic             hitEvtStat;
   logic             hitEvtMask;
   logic [DAT_W-1:0] rdVal;

   // register contents
   logic [SIDE_W-1:0] priReq;
   logic [SIDE_W-1:0] secReq;
   logic [SIDE_W-1:0] priMsk;
   logic [SIDE_W-1:0] secMsk;
   logic [EVT_W-1:0]  evtStat;
   logic [EVT_W-1:0]  evtMsk;

   // per-register set and clear strobes
   logic [SIDE_W-1:0] priReqSet;
   logic [SIDE_W-1:0] priReqClr;
   logic [SIDE_W-1:0] secReqSet;
   logic [SIDE_W-1:0] secReqClr;
   logic [SIDE_W-1:0] priMskSet;
   logic [SIDE_W-1:0] priMskClr;
   logic [SIDE_W-1:0] secMskSet;
   logic [SIDE_W-1:0] secMskClr;
   logic [EVT_W-1:0]  evtSet;
   logic [EVT_W-1:0]  evtClr;
   logic [EVT_W-1:0]  evtMskSet;
   logic [EVT_W-1:0]  evtMskClr;
   logic              priPend;
   logic              secPend;

   // wishbone classic slave: ack one cycle after the request is seen,
   // write applied at the edge where ack is high, read data latched
   // at the taking edge so it is stable all through the ack cycle
   assign take = wb_cyc_i & wb_stb_i & (busStFf == BUS_IDLE);
   assign wrDo = wb_cyc_i & wb_stb_i & wb_we_i & ackFf;

   always_comb begin
      for (int b = 0; b < SEL_W; b++) begin
         selMask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end

   assign wrData     = wb_dat_i & selMask;
   assign hitReqClr  = wrDo & (wb_adr_i == OFS_REQ_CLR);
   assign hitReqSet  = wrDo & (wb_adr_i == OFS_REQ_SET);
   assign hitMskClr  = wrDo & (wb_adr_i == OFS_MSK_CLR);
   assign hitMskSet  = wrDo & (wb_adr_i == OFS_MSK_SET);
   assign hitEvtStat = wrDo & (wb_adr_i == OFS_EVT_STAT);
   assign hitEvtMask = wrDo & (wb_adr_i == OFS_EVT_MASK);

   always_comb begin
      nxt_busSt = busStFf;
      nxt_ack   = ackFf;
      nxt_dat   = datFf;
      if (clkEn) begin
         case (busStFf)
            BUS_IDLE: begin
               if (take) begin
                  nxt_busSt = BUS_ACK;
                  nxt_ack   = 1'b1;
                  if (!wb_we_i) begin
                     nxt_dat = rdVal;
                  end
               end
            end
            BUS_ACK: begin
               // ack drops after one cycle; master must release before next
               nxt_busSt = BUS_IDLE;
               nxt_ack   = 1'b0;
            end
            default: begin
               nxt_busSt = BUS_IDLE;
               nxt_ack   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busStFf <= BUS_IDLE;
         ackFf   <= 1'b0;
         datFf   <= DAT_RST;
      end else begin
         busStFf <= nxt_busSt;
         ackFf   <= nxt_ack;
         datFf   <= nxt_dat;
      end
   end

   // read mux; both request offsets show requests, both mask offsets
   // show masks, unmapped addresses read zero but are still acked
   always_comb begin
      case (wb_adr_i)
         OFS_REQ_CLR:  rdVal = {secReq, priReq};
         OFS_REQ_SET:  rdVal = {secReq, priReq};
         OFS_MSK_CLR:  rdVal = {secMsk, priMsk};
         OFS_MSK_SET:  rdVal = {secMsk, priMsk};
         OFS_EVT_STAT: rdVal = {{(DAT_W-EVT_W){1'b0}}, evtStat};
         OFS_EVT_MASK: rdVal = {{(DAT_W-EVT_W){1'b0}}, evtMsk};
         default:      rdVal = UNMAPPED_RD;
      endcase
   end

   // doorbell request and mask strobes
   assign priReqClr = hitReqClr ? wrData[PRI_LSB +: SIDE_W] : REQ_RST;
   assign secReqClr = hitReqClr ? wrData[SEC_LSB +: SIDE_W] : REQ_RST;
   assign priReqSet = hitReqSet ? wrData[PRI_LSB +: SIDE_W] : REQ_RST;
   assign secReqSet = hitReqSet ? wrData[SEC_LSB +: SIDE_W] : REQ_RST;
   assign priMskClr = hitMskClr ? wrData[PRI_LSB +: SIDE_W] : REQ_RST;
   assign secMskClr = hitMskClr ? wrData[SEC_LSB +: SIDE_W] : REQ_RST;
   assign priMskSet = hitMskSet ? wrData[PRI_LSB +: SIDE_W] : REQ_RST;
   assign secMskSet = hitMskSet ? wrData[SEC_LSB +: SIDE_W] : REQ_RST;

   dbirq_w1_reg #(.WIDTH(SIDE_W), .RST_VAL(REQ_RST)) u_priReq (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .setBits  (priReqSet),
      .clrBits  (priReqClr),
      .q        (priReq)
   );

   dbirq_w1_reg #(.WIDTH(SIDE_W), .RST_VAL(REQ_RST)) u_secReq (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .setBits  (secReqSet),
      .clrBits  (secReqClr),
      .q        (secReq)
   );

   dbirq_w1_reg #(.WIDTH(SIDE_W), .RST_VAL(MSK_RST)) u_priMsk (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .setBits  (priMskSet),
      .clrBits  (priMskClr),
      .q        (priMsk)
   );

   dbirq_w1_reg #(.WIDTH(SIDE_W), .RST_VAL(MSK_RST)) u_secMsk (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .setBits  (secMskSet),
      .clrBits  (secMskClr),
      .q        (secMsk)
   );

   // event status: a doorbell bit going from 0 to 1 on either side;
   // set beats the one-to-clear so a ring during the clear survives
   assign evtSet[EVT_PRI] = |(priReqSet & ~priReq);
   assign evtSet[EVT_SEC] = |(secReqSet & ~secReq);
   assign evtClr          = hitEvtStat ? wrData[EVT_W-1:0] : EVT_RST;
   // plain read/write mask built from set and clear of the written word
   assign evtMskSet       = hitEvtMask ? wrData[EVT_W-1:0] : EVT_RST;
   assign evtMskClr       = hitEvtMask ? ~wrData[EVT_W-1:0] : EVT_RST;

   dbirq_w1_reg #(.WIDTH(EVT_W), .RST_VAL(EVT_RST)) u_evtStat (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .setBits  (evtSet),
      .clrBits  (evtClr),
      .q        (evtStat)
   );

   dbirq_w1_reg #(.WIDTH(EVT_W), .RST_VAL(EVT_MSK_RST)) u_evtMsk (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .setBits  (evtMskSet),
      .clrBits  (evtMskClr),
      .q        (evtMsk)
   );

   // interrupt lines, registered so each output leaves a flip-flop;
   // costs one cycle of latency after the request bit changes
   assign priPend = |(priReq & ~priMsk);
   assign secPend = |(secReq & ~secMsk);

   always_comb begin
      nxt_priIrq = priIrqFf;
      nxt_secIrq = secIrqFf;
      nxt_irqOut = irqOutFf;
      if (clkEn) begin
         nxt_priIrq = priPend;
         nxt_secIrq = secPend;
         nxt_irqOut = |(evtStat & ~evtMsk);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         priIrqFf <= 1'b0;
         secIrqFf <= 1'b0;
         irqOutFf <= 1'b0;
      end else begin
         priIrqFf <= nxt_priIrq;
         secIrqFf <= nxt_secIrq;
         irqOutFf <= nxt_irqOut;
      end
   end

   assign wb_ack_o = ackFf;
   assign wb_dat_o = datFf;
   assign priIrq   = priIrqFf;
   assign secIrq   = secIrqFf;
   assign irqOut   = irqOutFf;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   logic [SIDE_W-1:0] wrLo;
   logic [SIDE_W-1:0] wrHi;
   assign wrLo = wrData[PRI_LSB +: SIDE_W];
   assign wrHi = wrData[SEC_LSB +: SIDE_W];

   sequence sTake;
      clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence sWrite(logic [ADR_W-1:0] ofs);
      clkEn && wrDo && (wb_adr_i == ofs);
   endsequence

   sequence sRead(logic [ADR_W-1:0] ofs);
      sTake ##0 (!wb_we_i && (wb_adr_i == ofs));
   endsequence

   property pAckPulse;
      sTake ##1 clkEn |-> wb_ack_o ##1 !wb_ack_o;
   endproperty

   chk_ack_one_pulse: assert property (pAckPulse)
      else $error("ack did not pulse for one cycle");

   chk_sec_clear: assert property (sWrite(OFS_REQ_CLR) |=>
      (secReq & $past(wrHi)) == 16'h0000)
      else $error("secondary request not cleared");

   chk_sec_read: assert property (sRead(OFS_REQ_CLR) |=>
      wb_dat_o[31:16] == $past(secReq))
      else $error("secondary request readback wrong");

   chk_pri_set: assert property (sWrite(OFS_REQ_SET) |=>
      (priReq & $past(wrLo)) == $past(wrLo))
      else $error("primary request not set");

   chk_pri_read: assert property (sRead(OFS_REQ_SET) |=>
      wb_dat_o[15:0] == $past(priReq))
      else $error("primary request readback wrong");

   chk_sec_set: assert property (sWrite(OFS_REQ_SET) |=>
      (secReq & $past(wrHi)) == $past(wrHi))
      else $error("secondary request not set");

   chk_pmask_clear: assert property (sWrite(OFS_MSK_CLR) |=>
      (priMsk & $past(wrLo)) == 16'h0000)
      else $error("primary mask not cleared");

   chk_pmask_read: assert property (sRead(OFS_MSK_CLR) |=>
      wb_dat_o[15:0] == $past(priMsk))
      else $error("primary mask readback wrong");

   chk_smask_clear: assert property (sWrite(OFS_MSK_CLR) |=>
      (secMsk & $past(wrHi)) == 16'h0000)
      else $error("secondary mask not cleared");

   chk_pmask_set: assert property (sWrite(OFS_MSK_SET) |=>
      (priMsk & $past(wrLo)) == $past(wrLo))
      else $error("primary mask not set");

   chk_pmask_rdset: assert property (sRead(OFS_MSK_SET) |=>
      wb_dat_o[15:0] == $past(priMsk))
      else $error("primary mask readback at set offset wrong");

   chk_pri_clear: assert property (sWrite(OFS_REQ_CLR) |=>
      (priReq & $past(wrLo)) == 16'h0000)
      else $error("primary request not cleared");

   chk_smask_set: assert property (sWrite(OFS_MSK_SET) |=>
      (secMsk & $past(wrHi)) == $past(wrHi))
      else $error("secondary mask not set");

   chk_req_untouched: assert property (sWrite(OFS_REQ_SET) |=>
      (priReq & ~$past(wrLo)) == ($past(priReq) & ~$past(wrLo)))
      else $error("primary request bit written zero changed");

   chk_side_irq: assert property (clkEn |=>
      priIrq == $past(priPend) && secIrq == $past(secPend))
      else $error("side interrupt line does not follow pending requests");

   chk_evt_sticky: assert property (clkEn && evtStat[EVT_PRI] && !evtClr[EVT_PRI] |=>
      evtStat[EVT_PRI])
      else $error("event status bit lost without clear");

endmodule // dbirq_top

// File: dbirq_host.sv
`timescale 1ns/1ps
module dbirq_host
   import dbirq_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             ackIn,
   input  wire logic [DAT_W-1:0] datIn,
   output logic                  cyc,
   output logic                  stb,
   output logic                  we,
   output logic      [ADR_W-1:0] adr,
   output logic      [SEL_W-1:0] sel,
   output logic      [DAT_W-1:0] dat
);
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we  = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0000_0000;
   end

   // one classic cycle; after release adr and dat show the inverse so stale values never match
   task automatic access(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                         input logic [SEL_W-1:0] s, output logic [DAT_W-1:0] q);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      do @(posedge core_clk); while (ackIn !== 1'b1);
      q = datIn;
      cyc <= 1'b0;
      stb <= 1'b0;
      adr <= ~a;
      dat <= ~d;
   endtask
endmodule // dbirq_host

// File: doorbell_irq_set_clear_bench.sv
`timescale 1ns/1ps
module doorbell_irq_set_clear_bench;
   import dbirq_pkg::*;
   logic             core_clk = 1'b0;
   logic             arst_n   = 1'b0;
   logic             clkEn    = 1'b1;
   logic             wbCyc;
   logic             wbStb;
   logic             wbWe;
   logic [ADR_W-1:0] wbAdr;
   logic [SEL_W-1:0] wbSel;
   logic [DAT_W-1:0] wbDatI;
   logic [DAT_W-1:0] wbDatO;
   logic             wbAck;
   logic             priIrq;
   logic             secIrq;
   logic             irqOut;
   int               mismatches  = 0;
   int               check_count = 0;
   int unsigned      mReq;
   int unsigned      mMsk;
   int unsigned      mEvt;
   int unsigned      mEvtMsk;
   logic [DAT_W-1:0] rdVal;
   logic [ADR_W-1:0] ofsTab [6];

   always #2.5 core_clk = ~core_clk;

   dbirq_host host (.core_clk(core_clk), .ackIn(wbAck), .datIn(wbDatO), .cyc(wbCyc),
                    .stb(wbStb), .we(wbWe), .adr(wbAdr), .sel(wbSel), .dat(wbDatI));

   dbirq_top dut (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .wb_cyc_i(wbCyc),
                  .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
                  .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .priIrq(priIrq),
                  .secIrq(secIrq), .irqOut(irqOut));

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic mdlReset();
      mReq    = {REQ_RST, REQ_RST};
      mMsk    = {MSK_RST, MSK_RST};
      mEvt    = EVT_RST;
      mEvtMsk = EVT_MSK_RST;
   endtask

   // model update first, then the real bus cycle
   task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                     input logic [SEL_W-1:0] s);
      logic [31:0] m;
      int unsigned nw;
      for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{s[i]}};
      m = m & d;
      case (a)
         OFS_REQ_CLR: mReq = mReq & ~m;
         OFS_REQ_SET: begin
            nw   = m & ~mReq;
            mReq = mReq | m;
            if (nw[15:0] != 0) mEvt = mEvt | 1;
            if (nw[31:16] != 0) mEvt = mEvt | 2;
         end
         OFS_MSK_CLR:  mMsk = mMsk & ~m;
         OFS_MSK_SET:  mMsk = mMsk | m;
         OFS_EVT_STAT: mEvt = mEvt & ~m[1:0];
         OFS_EVT_MASK: mEvtMsk = m[1:0];
         default: ;
      endcase
      host.access(1'b1, a, d, s, rdVal);
   endtask

   task automatic rdCheck(input logic [ADR_W-1:0] a, input logic [31:0] exp, input string w);
      host.access(1'b0, a, 32'h0000_0000, 4'hF, rdVal);
      check(rdVal, exp, w);
   endtask

   task automatic checkAll();
      rdCheck(OFS_REQ_CLR, mReq, "req at 070");
      rdCheck(OFS_REQ_SET, mReq, "req at 074");
      rdCheck(OFS_MSK_CLR, mMsk, "mask at 078");
      rdCheck(OFS_MSK_SET, mMsk, "mask at 07C");
      rdCheck(OFS_EVT_STAT, mEvt, "event status");
      rdCheck(OFS_EVT_MASK, mEvtMsk, "event mask");
      check({31'h0, priIrq}, {31'h0, |(mReq[15:0] & ~mMsk[15:0])}, "priIrq");
      check({31'h0, secIrq}, {31'h0, |(mReq[31:16] & ~mMsk[31:16])}, "secIrq");
      check({31'h0, irqOut}, {31'h0, |(mEvt & ~mEvtMsk)}, "irqOut");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end

   initial begin
      ofsTab = '{OFS_REQ_CLR, OFS_REQ_SET, OFS_MSK_CLR, OFS_MSK_SET, OFS_EVT_STAT, OFS_EVT_MASK};
      void'($urandom(32'h79d26a1f));
      mdlReset();
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      checkAll();
      rdCheck(8'h00, UNMAPPED_RD, "unmapped read");
      wr(8'h00, 32'hFFFF_FFFF, 4'hF);
      checkAll();
      $display("test reset done");
      // masked requests stay quiet until mask bits are cleared
      wr(OFS_REQ_SET, 32'hFFFF_FFFF, 4'hF);
      checkAll();
      wr(OFS_MSK_CLR, 32'h0001_0001, 4'hF);
      checkAll();
      wr(OFS_REQ_CLR, 32'h0001_0001, 4'h1);
      checkAll();
      wr(OFS_REQ_CLR, 32'hFFFF_0000, 4'hC);
      wr(OFS_MSK_SET, 32'h0000_0001, 4'hF);
      wr(OFS_EVT_MASK, 32'h0000_0000, 4'hF);
      checkAll();
      wr(OFS_EVT_STAT, 32'h0000_0003, 4'hF);
      checkAll();
      $display("test directed done");
      // pending line must not move while the enable is low
      wr(OFS_MSK_CLR, 32'h0000_0002, 4'hF);
      clkEn <= 1'b0;
      repeat (3) @(posedge core_clk);
      check({31'h0, priIrq}, 32'h0000_0000, "priIrq while frozen");
      clkEn <= 1'b1;
      checkAll();
      $display("test clock enable done");
      for (int i = 0; i < 40; i++) begin
         wr(ofsTab[$urandom_range(5)], $urandom, $urandom_range(15));
         checkAll();
      end
      $display("test random done");
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      mdlReset();
      checkAll();
      $display("test second reset done");
      conclude();
   end
endmodule // doorbell_irq_set_clear_bench
